// ==== dv/config_word_decode_protect_bench.sv ====
// Self-checking bench for the configuration decoder and protection gate.
// Assumes one 20 MHz clock and the programmer model in prog_partner.
`timescale 1ns/1ps
module config_word_decode_protect_bench
  import cfg_pkg::*;
;
  logic clk = 0;
  logic rst_i = 1;
  logic [13:0] nv1 = '0;
  logic [13:0] nv2 = '0;
  logic sleep = 0;
  logic lvp_entry = 0;
  logic [13:0] mem_rdata = '0;
  logic self_wr_req = 0;
  logic [14:0] self_wr_addr = '0;
  logic stack_push = 0;
  logic stack_pop = 0;
  logic cyc = 0;
  logic stb = 0;
  logic we = 0;
  logic [17:0] adr = '0;
  logic [3:0] sel = 4'hf;
  logic [31:0] dat = '0;
  logic [31:0] wb_dat;
  logic ack, loaded, ext_ack, ext_ref, mem_wr, nv_wr, p_er, d_er, wr_ok, stk_rst;
  logic [13:0] ext_rd;
  logic [13:0] nv_wd, mem_wd;
  logic [14:0] mem_ad;
  logic nv_sel;
  space_t mem_sp;
  ext_req_t ext;
  clk_ctrl_t clk_ctrl, ec;
  sys_ctrl_t sys_ctrl, es;
  logic [13:0] w1, w2, e2, mrd;
  logic [14:0] lim;
  logic [10:0] msk;
  logic [2:0] ct, k;
  logic lve, p, d, b;
  logic [31:0] r;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  int seed = 49;

  always #25 clk = ~clk;

  config_word_decode_protect i_dut (.clk_i(clk), .rst_i(rst_i), .nv_word1_i(nv1),
    .nv_word2_i(nv2), .sleep_i(sleep), .lvp_entry_i(lvp_entry), .ext_i(ext),
    .mem_rdata_i(mem_rdata), .self_wr_req_i(self_wr_req), .self_wr_addr_i(self_wr_addr),
    .stack_push_i(stack_push), .stack_pop_i(stack_pop), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat),
    .wb_ack_o(ack), .clk_ctrl_o(clk_ctrl), .sys_ctrl_o(sys_ctrl), .loaded_o(loaded),
    .ext_ack_o(ext_ack), .ext_refused_o(ext_ref), .ext_rdata_o(ext_rd), .mem_wr_o(mem_wr),
    .mem_space_o(mem_sp), .mem_addr_o(mem_ad), .mem_wdata_o(mem_wd), .nv_wr_o(nv_wr),
    .nv_wr_sel_o(nv_sel), .nv_wdata_o(nv_wd), .prog_erase_o(p_er), .data_erase_o(d_er),
    .self_wr_ok_o(wr_ok),
    .stack_reset_o(stk_rst));

  prog_partner i_prog (.clk_i(clk), .ack_i(ext_ack), .refused_i(ext_ref),
    .rdata_i(ext_rd), .side_i({mem_wr, nv_wr, p_er, d_er}), .ext_o(ext));

  task automatic finish_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Classic single cycle; ack and data are taken at the edge that sees ack high
  task automatic wb(input logic w, input logic [15:0] idx, input logic [31:0] wd,
                    output logic [31:0] rd);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= wd;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    rd = wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic xc(input string nm, input logic w, input space_t sp, input logic [14:0] a,
                    input logic [13:0] wd, input logic er, input logic [19:0] exp);
    logic [19:0] res;
    i_prog.xfer(w, sp, a, wd, er, res);
    chk(nm, res, exp);
  endtask : xc

  // One-cycle strobe on {self write, push, pop}; result seen one cycle later
  task automatic pulse(input logic [2:0] s, input logic [14:0] a, output logic res);
    @(posedge clk);
    {self_wr_req, stack_push, stack_pop} <= s;
    self_wr_addr <= a;
    @(posedge clk);
    {self_wr_req, stack_push, stack_pop} <= 3'b000;
    @(posedge clk);
    res = s[2] ? wr_ok : stk_rst;
  endtask : pulse

  function automatic logic md(input logic [1:0] m, input logic sl, input logic sw);
    return m == EN_ALWAYS || (m == EN_RUN_ONLY && !sl) || (m == EN_SOFTWARE && sw);
  endfunction : md

  initial begin
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      w1 = 14'($random(seed));
      w2 = 14'($random(seed)) | 14'h0010;
      // Walk every mode code across the iterations
      w1[10:9] = k[1:0];
      w1[4:3] = ~k[1:0];
      w1[2:0] = k;
      w2[1:0] = k[1:0];
      ct = 3'($random(seed));
      mrd = 14'($random(seed));
      lve = k[0];
      rst_i <= 1'b1;
      nv1 <= w1;
      nv2 <= w2;
      sleep <= k[2];
      lvp_entry <= lve;
      mem_rdata <= mrd;
      repeat (8) @(posedge clk);
      rst_i <= 1'b0;
      nv1 <= ~w1;
      nv2 <= ~w2;
      wb(1'b1, CTRL_IDX, {29'h0, ct}, r);
      repeat (2) @(posedge clk);
      e2 = w2 | CFG2_ONES;
      p = !w1[7];
      d = !w1[8];
      ec = '{w1[13], w1[12], w1[2:0] > 2 && !w1[11], w1[2:0] <= 2, w2[8], w1[2:0],
             w1[2:0] >= 5, w1[2:0] == 4, w1[2:0] == 3, w1[2:0] <= 2};
      es = '{md(w1[10:9], k[2], ct[0]), w2[10], md(w1[4:3], k[2], ct[1]), !w1[5], w1[6],
             w1[6] | ct[2], w2[13], !w2[12], w2[9], w2[1:0]};
      // Reset pin bits are don't-care while low-voltage programming is on
      msk = w2[13] ? 11'h79f : 11'h7ff;
      chk("loaded", loaded, 1);
      chk("clk_ctrl", clk_ctrl, ec);
      chk("sys_ctrl", sys_ctrl & msk, es & msk);
      wb(1'b1, CFG1_IDX, 32'h0, r);
      wb(1'b0, CFG1_IDX, 32'h0, r);
      chk("word1", r, w1);
      wb(1'b0, CFG2_IDX, 32'h0, r);
      chk("word2", r, e2);
      wb(1'b0, 16'h8010, 32'h0, r);
      chk("unmapped", r, 0);
      xc("prog_rd", 0, SPACE_PROG, 15'h0123, 0, 0, {1'b1, p, 4'h0, p ? 14'h0 : mrd});
      xc("prog_wr", 1, SPACE_PROG, 15'h0123, mrd, 0, {1'b1, p, !p, 17'h0});
      xc("data_rd", 0, SPACE_DATA, 15'h0040, 0, 0, {1'b1, d, 4'h0, d ? 14'h0 : mrd});
      xc("data_wr", 1, SPACE_DATA, 15'h0040, mrd, 0, {1'b1, d, !d, 17'h0});
      chk("mem_req", {mem_sp, mem_ad, mem_wd}, {SPACE_DATA, 15'h0040, mrd});
      xc("cfg_rd", 0, SPACE_CFG, 15'h0008, 0, 0, {6'h20, e2});
      xc("erase", 1, SPACE_CFG, 15'h0007, w1 | 14'h0180, 1, {3'h4, 1'b1, p, d, 14'h0});
      chk("nv_req", {nv_sel, nv_wd}, {1'b0, w1 | 14'h0180});
      xc("lvp_wr", 1, SPACE_CFG, 15'h0008, 14'h0010, 0, {1'b1, lve, 1'b0, !lve, 16'h0});
      chk("nv_keep", {nv_sel, nv_wd}, lve ? {1'b0, w1 | 14'h0180} : {1'b1, 14'h0010});
      lim = w2[1:0] == 2 ? 15'h01ff : (w2[1:0] == 1 ? 15'h07ff : 15'h0fff);
      pulse(3'b100, lim, b);
      chk("wr_at_lim", b, w2[1:0] == 3);
      pulse(3'b100, lim + 15'h1, b);
      chk("wr_above", b, 1);
      pulse(3'b001, 0, b);
      chk("underflow", b, w2[9]);
      for (int j = 0; j < 16; j++) begin
        pulse(3'b010, 0, b);
        chk("push", b, 0);
      end
      pulse(3'b010, 0, b);
      chk("overflow", b, w2[9]);
      wb(1'b0, STAT_IDX, 32'h0, r);
      chk("status", r, {28'h0, 1'b1, lve, 2'b11});
      wb(1'b1, STAT_IDX, 32'h3, r);
      wb(1'b0, STAT_IDX, 32'h0, r);
      chk("status_clr", r, {28'h0, 1'b1, lve, 2'b00});
    end
    finish_test();
  end
endmodule : config_word_decode_protect_bench

// ==== dv/prog_partner.sv ====
// External programmer model: one access at a time on the ext_req_t carrier.
// Assumes the block answers one cycle after the edge that takes the request.
`timescale 1ns/1ps
module prog_partner
  import cfg_pkg::*;
(
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic refused_i,
  input wire logic [WORD_W-1:0] rdata_i,
  input wire logic [3:0] side_i,
  output ext_req_t ext_o
);
  initial ext_o = '0;

  task automatic xfer(input logic we, input space_t sp, input logic [MEM_ADDR_W-1:0] a,
                      input logic [WORD_W-1:0] wd, input logic er,
                      output logic [WORD_W+5:0] res);
    logic [WORD_W-1:0] d;
    d = wd;
    if (we && sp == SPACE_CFG && a == 15'h0008) d[4] = 1'b1;
    // Debug-pin bit goes out exactly as the caller set it
    @(posedge clk_i);
    ext_o <= '{1'b1, we, sp, a, d, er};
    @(posedge clk_i);
    // Released lines other than space show inverted values so stale data cannot pass
    ext_o <= '{1'b0, ~we, sp, ~a, ~d, ~er};
    @(posedge clk_i);
    res = {ack_i, refused_i, side_i, rdata_i};
  endtask : xfer
endmodule : prog_partner

// ==== hdl/cfg_pkg.sv ====
// Constants and carriers for the configuration word loader and protection gate.
// Assumes a single 20 MHz clock and word-indexed Wishbone register access.
package cfg_pkg;
  localparam int WORD_W = 14;
  localparam int WB_ADDR_W = 18;
  localparam int MEM_ADDR_W = 15;
  localparam logic [15:0] CFG1_IDX = 16'h8007;
  localparam logic [15:0] CFG2_IDX = 16'h8008;
  localparam logic [15:0] STAT_IDX = 16'h8009;
  localparam logic [15:0] CTRL_IDX = 16'h800a;
  // First word fields
  localparam int B_FAILSAFE = 13;
  localparam int B_SWITCHOVER = 12;
  localparam int B_CLOCK_OUTPUT_PIN_N = 11;
  localparam int B_BOR_HI = 10;
  localparam int B_BOR_LO = 9;
  localparam int B_DATA_PROT_N = 8;
  localparam int B_PROG_PROT_N = 7;
  localparam int B_RESET_PIN = 6;
  localparam int B_POWERUP_TIMER_N = 5;
  localparam int B_WDT_HI = 4;
  localparam int B_WDT_LO = 3;
  localparam int B_OSC_HI = 2;
  localparam int B_OSC_LO = 0;
  // Second word fields
  localparam int B_LVP = 13;
  localparam int B_DEBUG_N = 12;
  localparam int B_BOR_TRIP = 10;
  localparam int B_STACK_RST = 9;
  localparam int B_PLL = 8;
  localparam int B_WRT_HI = 1;
  localparam int B_WRT_LO = 0;
  localparam logic [WORD_W-1:0] CFG2_ONES = 14'h08ec;
  localparam logic [WORD_W-1:0] WORD_BLANK = 14'h3fff;
  // Two-bit enable modes, shared by brown-out and watchdog
  localparam logic [1:0] EN_ALWAYS = 2'h3;
  localparam logic [1:0] EN_RUN_ONLY = 2'h2;
  localparam logic [1:0] EN_SOFTWARE = 2'h1;
  localparam logic [1:0] EN_OFF = 2'h0;
  // Oscillator select codes
  localparam logic [2:0] OSC_EXT_HIGH = 3'h7;
  localparam logic [2:0] OSC_EXT_MED = 3'h6;
  localparam logic [2:0] OSC_EXT_LOW = 3'h5;
  localparam logic [2:0] OSC_INTERNAL = 3'h4;
  localparam logic [2:0] OSC_EXT_RC = 3'h3;
  localparam logic [2:0] OSC_XTAL_HS = 3'h2;
  localparam logic [2:0] OSC_XTAL_MED = 3'h1;
  localparam logic [2:0] OSC_XTAL_LP = 3'h0;
  // Self-write protection limits
  localparam logic [1:0] WRT_NONE = 2'h3;
  localparam logic [1:0] WRT_LOW = 2'h2;
  localparam logic [1:0] WRT_HALF = 2'h1;
  localparam logic [MEM_ADDR_W-1:0] WRT_LIM_LOW = 15'h01ff;
  localparam logic [MEM_ADDR_W-1:0] WRT_LIM_HALF = 15'h07ff;
  localparam logic [MEM_ADDR_W-1:0] WRT_LIM_ALL = 15'h0fff;
  // Stack depth
  localparam logic [4:0] STACK_LEVELS = 5'h10;
  // Status and control bit positions
  localparam int S_OVF = 0;
  localparam int S_UNF = 1;
  localparam int S_LVP_ENTRY = 2;
  localparam int S_LOADED = 3;
  localparam int C_SW_BOR = 0;
  localparam int C_SW_WDT = 1;
  localparam int C_PULLUP = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  typedef enum logic [1:0] {SPACE_PROG, SPACE_DATA, SPACE_CFG, SPACE_NONE} space_t;

  typedef struct packed {
    logic failsafe_monitor_enable;
    logic int_ext_switchover_enable;
    logic clock_output_drive;
    logic crystal_pin_osc;
    logic clock_multiplier_enable;
    logic [2:0] osc_source_select;
    logic ext_clock;
    logic internal_oscillator;
    logic external_rc_oscillator;
    logic crystal;
  } clk_ctrl_t;

  typedef struct packed {
    logic brownout_active;
    logic brownout_trip_select;
    logic watchdog_active;
    logic powerup_timer_enable;
    logic master_reset_pin_en;
    logic reset_pin_pullup;
    logic low_volt_program_enable;
    logic debug_pins_owned;
    logic stack_fault_reset_enable;
    logic [1:0] self_write_protect;
  } sys_ctrl_t;

  typedef struct packed {
    logic req;
    logic we;
    space_t space;
    logic [MEM_ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
    logic erase;
  } ext_req_t;
endpackage : cfg_pkg

// ==== hdl/config_word_decode_protect.sv ====
// Configuration word loader, decoder and external-access protection gate.
// Assumes nonvolatile words valid during reset, programmer strobes and CPU
// events synchronous to clk_i, and a classic Wishbone master.
//
// Behaviour
// (RL1) First word at 8007h, second at 8008h; both readable.
// (RL2) First word bit 13 enables the fail-safe clock monitor.
// (RL3) First word bit 12 enables internal/external switchover.
// (RL4) Bit 11: crystal modes keep oscillator pin; else 0 drives clock out.
// (RL5) Brown-out mode: 11 on, 10 off in sleep, 01 software, 00 off.
// (RL6) First word bit 8 low enables data memory protection.
// (RL7) First word bit 7 low enables program memory protection.
// (RL8) Bit 6 ignored under low-voltage programming; else reset pin or input.
// (RL9) First word bit 5 low enables the power-up timer.
// (RL10) Brown-out enable never turns on the power-up timer.
// (RL11) Watchdog mode: 11 on, 10 off in sleep, 01 software, 00 off.
// (RL12) Oscillator field decodes external clock, internal, RC, crystal modes.
// (RL13) Second word bit 13 enables low-voltage programming entry.
// (RL14) Second word bit 12 low gives programming pins to the debugger.
// (RL15) Second word bit 10 high selects the low brown-out trip point.
// (RL16) Second word bit 9 high makes stack faults reset the device.
// (RL17) Second word bit 8 enables the times-four clock multiplier.
// (RL18) Unimplemented second word bits read 1; programmer sets bit 4.
// (RL19) Self-write field: 11 none, 10 to 1FFh, 01 to 7FFh, 00 to FFFh.
// (RL20) Under low-voltage entry, writing the low-voltage bit to 0 is refused.
// (RL21) Program protection blocks external writes, external reads return zeros.
// (RL22) Unprotecting program erases it; unprotecting data during erase erases data.
// (RL23) Program and data protection are independent; internal access unaffected.
// (RL24) Data protection blocks external data reads and writes.
// (RL25) Stack fault past sixteen levels or below one resets and flags.
// (RL26) Words load during reset and controls hold until next reset; brown-out, watchdog and pull-up controls follow sleep and control bits.
`timescale 1ns/1ps
module config_word_decode_protect
  import cfg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WORD_W-1:0] nv_word1_i,
  input wire logic [WORD_W-1:0] nv_word2_i,
  input wire logic sleep_i,
  input wire logic lvp_entry_i,
  input wire ext_req_t ext_i,
  input wire logic [WORD_W-1:0] mem_rdata_i,
  input wire logic self_wr_req_i,
  input wire logic [MEM_ADDR_W-1:0] self_wr_addr_i,
  input wire logic stack_push_i,
  input wire logic stack_pop_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output clk_ctrl_t clk_ctrl_o,
  output sys_ctrl_t sys_ctrl_o,
  output logic loaded_o,
  output logic ext_ack_o,
  output logic ext_refused_o,
  output logic [WORD_W-1:0] ext_rdata_o,
  output logic mem_wr_o,
  output space_t mem_space_o,
  output logic [MEM_ADDR_W-1:0] mem_addr_o,
  output logic [WORD_W-1:0] mem_wdata_o,
  output logic nv_wr_o,
  output logic nv_wr_sel_o,
  output logic [WORD_W-1:0] nv_wdata_o,
  output logic prog_erase_o,
  output logic data_erase_o,
  output logic self_wr_ok_o,
  output logic stack_reset_o
);

  typedef enum logic {ST_LOAD, ST_RUN} load_st_t;

  load_st_t st;
  logic [WORD_W-1:0] word1;
  logic [WORD_W-1:0] word2;
  logic [2:0] ctrl;
  logic ovf_flag;
  logic unf_flag;
  logic [4:0] depth;
  logic [15:0] wb_idx;
  logic wb_hit;
  logic wb_wr;
  logic stat_clr_ovf;
  logic stat_clr_unf;
  logic prog_open;
  logic data_open;
  logic cfg_lvp_bad;
  logic ext_allowed;
  logic push_ovf;
  logic pop_unf;

  function automatic logic mode_active(input logic [1:0] mode, input logic sleep,
                                       input logic sw);
    case (mode)
      EN_ALWAYS: mode_active = 1'b1;
      EN_RUN_ONLY: mode_active = !sleep;
      EN_SOFTWARE: mode_active = sw;
      default: mode_active = 1'b0;
    endcase
  endfunction : mode_active

  function automatic logic is_crystal(input logic [2:0] osc);
    is_crystal = (osc == OSC_XTAL_HS) || (osc == OSC_XTAL_MED) || (osc == OSC_XTAL_LP);
  endfunction : is_crystal

  // Loading happens only while reset is held, so the stored words cannot move later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= ST_LOAD;
    end else begin
      case (st)
        ST_LOAD: st <= ST_RUN;
        ST_RUN: st <= ST_RUN;
        default: st <= ST_LOAD;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word1 <= nv_word1_i; // RL26
      word2 <= nv_word2_i | CFG2_ONES; // RL18
    end
  end

  assign loaded_o = (st == ST_RUN);

  // Decoded clock controls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_ctrl_o <= '0;
    end else begin
      clk_ctrl_o.failsafe_monitor_enable <= word1[B_FAILSAFE]; // RL2
      clk_ctrl_o.int_ext_switchover_enable <= word1[B_SWITCHOVER]; // RL3
      clk_ctrl_o.crystal_pin_osc <= is_crystal(word1[B_OSC_HI:B_OSC_LO]); // RL4
      clk_ctrl_o.clock_output_drive <= !is_crystal(word1[B_OSC_HI:B_OSC_LO])
                                       && !word1[B_CLOCK_OUTPUT_PIN_N]; // RL4
      clk_ctrl_o.clock_multiplier_enable <= word2[B_PLL]; // RL17
      clk_ctrl_o.osc_source_select <= word1[B_OSC_HI:B_OSC_LO]; // RL12
      clk_ctrl_o.ext_clock <= (word1[B_OSC_HI:B_OSC_LO] == OSC_EXT_HIGH)
                              || (word1[B_OSC_HI:B_OSC_LO] == OSC_EXT_MED)
                              || (word1[B_OSC_HI:B_OSC_LO] == OSC_EXT_LOW); // RL12
      clk_ctrl_o.internal_oscillator <= (word1[B_OSC_HI:B_OSC_LO] == OSC_INTERNAL); // RL12
      clk_ctrl_o.external_rc_oscillator <= (word1[B_OSC_HI:B_OSC_LO] == OSC_EXT_RC); // RL12
      clk_ctrl_o.crystal <= is_crystal(word1[B_OSC_HI:B_OSC_LO]); // RL12
    end
  end

  // Decoded system controls; sleep and software bits may change at run time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_ctrl_o <= '0;
    end else begin
      sys_ctrl_o.brownout_active <= mode_active(word1[B_BOR_HI:B_BOR_LO], sleep_i,
                                                ctrl[C_SW_BOR]); // RL5
      sys_ctrl_o.watchdog_active <= mode_active(word1[B_WDT_HI:B_WDT_LO], sleep_i,
                                                ctrl[C_SW_WDT]); // RL11
      sys_ctrl_o.powerup_timer_enable <= !word1[B_POWERUP_TIMER_N]; // RL9 RL10
      sys_ctrl_o.master_reset_pin_en <= word2[B_LVP] || word1[B_RESET_PIN]; // RL8
      sys_ctrl_o.reset_pin_pullup <= (word2[B_LVP] || word1[B_RESET_PIN])
                                     ? 1'b1 : ctrl[C_PULLUP]; // RL8
      sys_ctrl_o.low_volt_program_enable <= word2[B_LVP]; // RL13
      sys_ctrl_o.debug_pins_owned <= !word2[B_DEBUG_N]; // RL14
      sys_ctrl_o.brownout_trip_select <= word2[B_BOR_TRIP]; // RL15
      sys_ctrl_o.stack_fault_reset_enable <= word2[B_STACK_RST]; // RL16
      sys_ctrl_o.self_write_protect <= word2[B_WRT_HI:B_WRT_LO]; // RL19
    end
  end

  // Self-write range check
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      self_wr_ok_o <= 1'b0;
    end else begin
      case (word2[B_WRT_HI:B_WRT_LO])
        WRT_NONE: self_wr_ok_o <= self_wr_req_i; // RL19
        WRT_LOW: self_wr_ok_o <= self_wr_req_i && (self_wr_addr_i > WRT_LIM_LOW); // RL19
        WRT_HALF: self_wr_ok_o <= self_wr_req_i && (self_wr_addr_i > WRT_LIM_HALF); // RL19
        default: self_wr_ok_o <= self_wr_req_i && (self_wr_addr_i > WRT_LIM_ALL); // RL19
      endcase
    end
  end

  // Stack depth tracking; flags set regardless of the reset enable
  assign push_ovf = stack_push_i && !stack_pop_i && (depth == STACK_LEVELS);
  assign pop_unf = stack_pop_i && !stack_push_i && (depth == 5'h00);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      depth <= 5'h00;
    end else if (stack_push_i && !stack_pop_i && depth != STACK_LEVELS) begin
      depth <= depth + 5'h01;
    end else if (stack_pop_i && !stack_push_i && depth != 5'h00) begin
      depth <= depth - 5'h01;
    end
  end

  // Flags survive the stack reset they cause; rst_i or a status write clears them, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_flag <= 1'b0;
      unf_flag <= 1'b0;
    end else begin
      if (push_ovf) begin
        ovf_flag <= 1'b1; // RL25
      end else if (stat_clr_ovf) begin
        ovf_flag <= 1'b0;
      end
      if (pop_unf) begin
        unf_flag <= 1'b1; // RL25
      end else if (stat_clr_unf) begin
        unf_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stack_reset_o <= 1'b0;
    end else begin
      stack_reset_o <= word2[B_STACK_RST] && (push_ovf || pop_unf); // RL16 RL25
    end
  end

  // External programmer gate; the CPU path never passes through here
  assign prog_open = word1[B_PROG_PROT_N]; // RL7 RL23
  assign data_open = word1[B_DATA_PROT_N]; // RL6 RL23
  assign cfg_lvp_bad = lvp_entry_i && (ext_i.addr == CFG2_IDX[MEM_ADDR_W-1:0])
                       && !ext_i.wdata[B_LVP];
  always_comb begin
    case (ext_i.space)
      SPACE_PROG: ext_allowed = prog_open; // RL21
      SPACE_DATA: ext_allowed = data_open; // RL24
      SPACE_CFG: ext_allowed = !(ext_i.we && cfg_lvp_bad); // RL20
      default: ext_allowed = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_ack_o <= 1'b0;
      ext_refused_o <= 1'b0;
      ext_rdata_o <= '0;
      mem_wr_o <= 1'b0;
      mem_space_o <= SPACE_NONE;
      mem_addr_o <= '0;
      mem_wdata_o <= '0;
    end else begin
      ext_ack_o <= ext_i.req && loaded_o;
      ext_refused_o <= ext_i.req && loaded_o && !ext_allowed; // RL20 RL21 RL24
      mem_wr_o <= ext_i.req && loaded_o && ext_i.we && ext_allowed
                  && (ext_i.space != SPACE_CFG); // RL21 RL24
      if (ext_i.req && loaded_o) begin
        mem_space_o <= ext_i.space;
        mem_addr_o <= ext_i.addr;
        mem_wdata_o <= ext_i.wdata;
        if (ext_i.we || !ext_allowed) begin
          ext_rdata_o <= '0; // RL21
        end else if (ext_i.space == SPACE_CFG) begin
          ext_rdata_o <= (ext_i.addr == CFG2_IDX[MEM_ADDR_W-1:0]) ? word2 : word1; // RL1
        end else begin
          ext_rdata_o <= mem_rdata_i;
        end
      end
    end
  end

  // Programming a configuration word; stored words change only after next reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nv_wr_o <= 1'b0;
      nv_wr_sel_o <= 1'b0;
      nv_wdata_o <= '0;
      prog_erase_o <= 1'b0;
      data_erase_o <= 1'b0;
    end else begin
      nv_wr_o <= 1'b0;
      prog_erase_o <= 1'b0;
      data_erase_o <= 1'b0;
      if (ext_i.req && loaded_o && ext_i.we && ext_i.space == SPACE_CFG && ext_allowed) begin
        nv_wr_o <= 1'b1;
        nv_wr_sel_o <= (ext_i.addr == CFG2_IDX[MEM_ADDR_W-1:0]);
        nv_wdata_o <= ext_i.wdata;
        if (ext_i.addr == CFG1_IDX[MEM_ADDR_W-1:0]) begin
          prog_erase_o <= !word1[B_PROG_PROT_N] && ext_i.wdata[B_PROG_PROT_N]; // RL22
          data_erase_o <= ext_i.erase && !word1[B_DATA_PROT_N]
                          && ext_i.wdata[B_DATA_PROT_N]; // RL22
        end
      end
    end
  end

  // Wishbone slave: word index is byte address over four, one wait state
  assign wb_idx = wb_adr_i[WB_ADDR_W-1:2];
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_hit && wb_we_i && wb_sel_i[0] && (wb_idx == STAT_IDX);
  assign stat_clr_ovf = wb_wr && wb_dat_i[S_OVF];
  assign stat_clr_unf = wb_wr && wb_dat_i[S_UNF];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        case (wb_idx)
          CFG1_IDX: wb_dat_o <= {18'h0, word1}; // RL1
          CFG2_IDX: wb_dat_o <= {18'h0, word2}; // RL1 RL18
          STAT_IDX: wb_dat_o <= {28'h0, loaded_o, lvp_entry_i, unf_flag, ovf_flag};
          CTRL_IDX: wb_dat_o <= {29'h0, ctrl};
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RESET;
    end else if (wb_hit && wb_we_i && wb_sel_i[0] && wb_idx == CTRL_IDX) begin
      ctrl <= wb_dat_i[2:0];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence ext_prog_req_s;
    ext_i.req && loaded_o && ext_i.space == SPACE_PROG && !prog_open;
  endsequence
  sequence refused_zero_s;
    ext_refused_o && ext_rdata_o == '0 && !mem_wr_o;
  endsequence

  prog_protect_a: assert property (ext_prog_req_s |=> refused_zero_s) // RL21
    else $error("protected program access not blocked");
  data_protect_a: assert property (ext_i.req && loaded_o && ext_i.space == SPACE_DATA // RL24
                                   && !data_open |=> ext_refused_o && !mem_wr_o)
    else $error("protected data access not blocked");
  lvp_refuse_a: assert property (ext_i.req && loaded_o && ext_i.we // RL20
                                 && ext_i.space == SPACE_CFG && cfg_lvp_bad |=> !nv_wr_o)
    else $error("low-voltage bit cleared under low-voltage entry");
  prog_erase_a: assert property (prog_erase_o |-> !$past(word1[B_PROG_PROT_N]) && nv_wr_o) // RL22
    else $error("program erase without unprotect");
  data_erase_a: assert property (data_erase_o |-> !$past(word1[B_DATA_PROT_N]) && nv_wr_o) // RL22
    else $error("data erase without unprotect");
  stack_reset_a: assert property (push_ovf && word2[B_STACK_RST] // RL25
                                  |=> stack_reset_o && ovf_flag)
    else $error("stack overflow did not reset");
  stack_quiet_a: assert property (!word2[B_STACK_RST] |=> !stack_reset_o) // RL16
    else $error("stack reset while disabled");
  powerup_timer_indep_a: assert property (loaded_o |=> sys_ctrl_o.powerup_timer_enable // RL9 RL10
                                 == !word1[B_POWERUP_TIMER_N])
    else $error("power-up timer not following its own bit");
  clock_output_pin_xtal_a: assert property (loaded_o && is_crystal(word1[B_OSC_HI:B_OSC_LO]) // RL4
                                  |=> !clk_ctrl_o.clock_output_drive)
    else $error("clock out driven in crystal mode");
  selfwr_block_a: assert property (self_wr_req_i && word2[B_WRT_HI:B_WRT_LO] == WRT_LOW // RL19
                                   && self_wr_addr_i <= WRT_LIM_LOW |=> !self_wr_ok_o)
    else $error("self-write inside protected range allowed");
  cfg2_ones_a: assert property ((word2 & CFG2_ONES) == CFG2_ONES) // RL18
    else $error("unimplemented bits not one");
  words_hold_a: assert property ($stable(word1) && $stable(word2)) // RL26
    else $error("configuration words changed outside reset");
  wb_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer timing wrong");
endmodule : config_word_decode_protect
